// ### verilog/dcpwm_pkg.sv
// Package with register offsets, control fields, modes and types of the dual channel modulator
package dcpwm_pkg;
	// Special function register addresses
	localparam logic [7:0] ADDR_PULSE_LOW = 8'h00_B1;
	localparam logic [7:0] ADDR_PULSE_HIGH = 8'h00_B2;
	localparam logic [7:0] ADDR_CYCLE_LOW = 8'h00_B3;
	localparam logic [7:0] ADDR_CYCLE_HIGH = 8'h00_B4;
	localparam logic [7:0] ADDR_CONTROL = 8'h00_AE;
	// Reset values
	localparam logic [7:0] RESET_DATA = 8'h00_00;
	localparam logic [7:0] RESET_CONTROL = 8'h00_00;
	// Control field positions
	localparam int MODE_MSB = 6;
	localparam int MODE_LSB = 4;
	localparam int DIV_MSB = 3;
	localparam int DIV_LSB = 2;
	localparam int SRC_MSB = 1;
	localparam int SRC_LSB = 0;
	localparam logic [7:0] CONTROL_MASK = 8'h00_7F;
	// Divider terminal counts for divide by 1, 4, 16, 64
	localparam logic [5:0] DIV_TC_1 = 6'h00;
	localparam logic [5:0] DIV_TC_4 = 6'h03;
	localparam logic [5:0] DIV_TC_16 = 6'h0F;
	localparam logic [5:0] DIV_TC_64 = 6'h3F;
	// Operating modes
	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_SINGLE = 3'h1,
		MODE_TWIN8 = 3'h2,
		MODE_TWIN16 = 3'h3,
		MODE_NRZ = 3'h4,
		MODE_DUAL8 = 3'h5,
		MODE_RZ = 3'h6,
		MODE_HOLD = 3'h7
	} dcpwm_mode_type;
	// Register bus request
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dcpwm_sfr_req_type;
	// Pin drive pair
	typedef struct packed {
		logic first;
		logic second;
	} dcpwm_pins_type;
endpackage

// ### verilog/dcpwm_core.sv
// Dual channel pulse width and pulse density modulator with its register file
`timescale 1ns/1ps
// Notes on behaviour
// - Mode 0 stops waveforms and releases both pins to normal port use.
// - Mode 1: one output, period from cycle width, high time from pulse width.
// - Mode 2 uses cycle width low byte as common period of both outputs.
// - Mode 2 drops first output when counter equals pulse width low byte.
// - Mode 2 second output rises at cycle high match, falls at pulse high match.
// - Mode 2 with cycle high byte zero starts both outputs together.
// - Mode 3 counter spans full 16-bit range, ignoring cycle width.
// - Mode 3 first output high below pulse width, low from match to wrap.
// - Mode 3 second output high below cycle width, low from match to wrap.
// - Mode 3 both outputs rise together when the counter wraps to zero.
// - Mode 4 first output high exactly pulse-width clocks per 65536.
// - Mode 4 second output high exactly cycle-width clocks per 65536.
// - Pulse density spreads high clocks evenly instead of grouping them.
// - Mode 6 is mode 4 with each high clock returned to zero halfway.
// - Mode 6 first output duty from pulse width bytes, second from cycle width bytes.
// - Both outputs share one clock source and one divider.
// - Mode 5 gives two 8-bit outputs with separate duty and a shared 256-tick period.
// - Mode 7 disables waveforms, pins serve normal port function.
// - Four data bytes are read/write and reset to zero.
// - Mode field sits at control bits 6 to 4, codes 0 to 7.
// - Any write to the control register resets the counter.
// - Low byte goes to a shadow; high byte write commits both at cycle end.
// - Clock source by control bits 1:0, divided 1/4/16/64 by bits 3:2.
module dcpwm_core (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Clock sources for the modulator, taken as synchronous levels
	input wire logic [3:0] sourceTick,
	// Register bus
	input wire dcpwm_pkg::dcpwm_sfr_req_type sfrReq,
	output logic [7:0] sfrRdata,
	output logic sfrHit,
	// Pins
	output dcpwm_pkg::dcpwm_pins_type pinOut,
	output logic pinOe
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0] pulseLow_r, pulseHigh_r, cycleLow_r, cycleHigh_r;
	logic [7:0] pulseLowShadow_r, cycleLowShadow_r;
	logic [15:0] pulseAct_r, cycleAct_r;
	logic pulsePend_r, cyclePend_r;
	logic [7:0] control_r;
	logic [5:0] divCnt_r;
	logic [15:0] count_r;
	logic [16:0] accFirst_r, accSecond_r;
	logic outFirst_r, outSecond_r, rzPhase_r, rzFirst_r, rzSecond_r;
	logic srcPrev_r;
	logic pwmTick, cycleEnd, ctlWrite, srcLevel;
	logic [5:0] divTc;
	dcpwm_pkg::dcpwm_mode_type mode;

	// Byte-wide write strobe for a given address
	function automatic logic hitWrite(input dcpwm_pkg::dcpwm_sfr_req_type r, input logic [7:0] a);
		hitWrite = r.write && (r.addr == a);
	endfunction

	assign mode = dcpwm_pkg::dcpwm_mode_type'(control_r[dcpwm_pkg::MODE_MSB:dcpwm_pkg::MODE_LSB]);
	assign ctlWrite = hitWrite(sfrReq, dcpwm_pkg::ADDR_CONTROL);

	////////////////////////////////////////////////////////////////////////
	// Control register; bit 7 is not implemented and reads zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			control_r <= dcpwm_pkg::RESET_CONTROL;
		end else if (ctlWrite) begin
			control_r <= sfrReq.wdata & dcpwm_pkg::CONTROL_MASK;
		end
	end

	// Data bytes; low bytes also feed a shadow that only the high write commits
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pulseLow_r <= dcpwm_pkg::RESET_DATA;
			pulseHigh_r <= dcpwm_pkg::RESET_DATA;
			cycleLow_r <= dcpwm_pkg::RESET_DATA;
			cycleHigh_r <= dcpwm_pkg::RESET_DATA;
			pulseLowShadow_r <= dcpwm_pkg::RESET_DATA;
			cycleLowShadow_r <= dcpwm_pkg::RESET_DATA;
		end else begin
			if (hitWrite(sfrReq, dcpwm_pkg::ADDR_PULSE_LOW)) begin
				pulseLowShadow_r <= sfrReq.wdata;
			end
			if (hitWrite(sfrReq, dcpwm_pkg::ADDR_CYCLE_LOW)) begin
				cycleLowShadow_r <= sfrReq.wdata;
			end
			if (hitWrite(sfrReq, dcpwm_pkg::ADDR_PULSE_HIGH)) begin
				pulseHigh_r <= sfrReq.wdata;
				pulseLow_r <= pulseLowShadow_r;
			end
			if (hitWrite(sfrReq, dcpwm_pkg::ADDR_CYCLE_HIGH)) begin
				cycleHigh_r <= sfrReq.wdata;
				cycleLow_r <= cycleLowShadow_r;
			end
		end
	end

	// Read mux; low bytes read the shadow so a read after write returns it
	always_comb begin
		sfrRdata = 8'h00;
		sfrHit = 1'b1;
		case (sfrReq.addr)
			dcpwm_pkg::ADDR_PULSE_LOW: sfrRdata = pulseLowShadow_r;
			dcpwm_pkg::ADDR_PULSE_HIGH: sfrRdata = pulseHigh_r;
			dcpwm_pkg::ADDR_CYCLE_LOW: sfrRdata = cycleLowShadow_r;
			dcpwm_pkg::ADDR_CYCLE_HIGH: sfrRdata = cycleHigh_r;
			dcpwm_pkg::ADDR_CONTROL: sfrRdata = control_r;
			default: sfrHit = 1'b0;
		endcase
	end

	// Committed values take effect at cycle end; pending flags track high writes
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pulsePend_r <= 1'b0;
			cyclePend_r <= 1'b0;
			pulseAct_r <= 16'h0000;
			cycleAct_r <= 16'h0000;
		end else begin
			// Only a committed pair moves at cycle end; a control write reloads both
			if (ctlWrite || (cycleEnd && pulsePend_r)) begin
				pulseAct_r <= {pulseHigh_r, pulseLow_r};
			end
			if (ctlWrite || (cycleEnd && cyclePend_r)) begin
				cycleAct_r <= {cycleHigh_r, cycleLow_r};
			end
			// Set by a new high write wins over the commit clearing it
			pulsePend_r <= hitWrite(sfrReq, dcpwm_pkg::ADDR_PULSE_HIGH) || (pulsePend_r && !cycleEnd);
			cyclePend_r <= hitWrite(sfrReq, dcpwm_pkg::ADDR_CYCLE_HIGH) || (cyclePend_r && !cycleEnd);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Source select and edge detect: one shared tick for both channels
	assign srcLevel = sourceTick[control_r[dcpwm_pkg::SRC_MSB:dcpwm_pkg::SRC_LSB]];

	always_comb begin
		case (control_r[dcpwm_pkg::DIV_MSB:dcpwm_pkg::DIV_LSB])
			2'd0: divTc = dcpwm_pkg::DIV_TC_1;
			2'd1: divTc = dcpwm_pkg::DIV_TC_4;
			2'd2: divTc = dcpwm_pkg::DIV_TC_16;
			default: divTc = dcpwm_pkg::DIV_TC_64;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			srcPrev_r <= 1'b0;
		end else begin
			srcPrev_r <= srcLevel;
		end
	end

	// Divider counts source rising edges; restarted with the counter
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			divCnt_r <= 6'h00;
		end else if (ctlWrite) begin
			divCnt_r <= 6'h00;
		end else if (srcLevel && !srcPrev_r) begin
			divCnt_r <= (divCnt_r >= divTc) ? 6'h00 : divCnt_r + 6'h01;
		end
	end
	assign pwmTick = srcLevel && !srcPrev_r && (divCnt_r >= divTc);

	////////////////////////////////////////////////////////////////////////
	// Period end per mode; mode 3 and density modes use the full range
	always_comb begin
		case (mode)
			dcpwm_pkg::MODE_SINGLE: cycleEnd = pwmTick && (count_r >= cycleAct_r);
			dcpwm_pkg::MODE_TWIN8: cycleEnd = pwmTick && (count_r[7:0] >= cycleAct_r[7:0]);
			dcpwm_pkg::MODE_DUAL8: cycleEnd = pwmTick && (count_r[7:0] >= 8'hFF);
			default: cycleEnd = pwmTick && (count_r == 16'hFFFF);
		endcase
	end

	// Main counter; a control write restarts it and mode 7 holds it in reset
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count_r <= 16'h0000;
		end else if (ctlWrite || mode == dcpwm_pkg::MODE_HOLD || mode == dcpwm_pkg::MODE_OFF) begin
			count_r <= 16'h0000;
		end else if (cycleEnd) begin
			count_r <= 16'h0000;
		end else if (pwmTick) begin
			count_r <= count_r + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Density accumulators; carry out marks a high clock, spreading them evenly
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			accFirst_r <= 17'h0_0000;
			accSecond_r <= 17'h0_0000;
		end else if (ctlWrite) begin
			accFirst_r <= 17'h0_0000;
			accSecond_r <= 17'h0_0000;
		end else if (pwmTick) begin
			accFirst_r <= {1'b0, accFirst_r[15:0]} + {1'b0, pulseAct_r};
			accSecond_r <= {1'b0, accSecond_r[15:0]} + {1'b0, cycleAct_r};
		end
	end

	// Waveform state per mode; PWM modes start each cycle first output high, second high in modes 3, 5 (mode 2: cycle high zero)
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			outFirst_r <= 1'b0;
			outSecond_r <= 1'b0;
		end else if (ctlWrite) begin
			outFirst_r <= 1'b1;
			outSecond_r <= (mode == dcpwm_pkg::MODE_TWIN8) ? 1'b0 : 1'b1;
		end else if (pwmTick) begin
			case (mode)
				dcpwm_pkg::MODE_SINGLE: begin
					outFirst_r <= cycleEnd || ((count_r + 16'h0001) < pulseAct_r);
					outSecond_r <= 1'b0;
				end
				dcpwm_pkg::MODE_TWIN8: begin
					// Next count decides the level; zero rise time keeps both in step
					outFirst_r <= cycleEnd || ((count_r[7:0] + 8'h01) != pulseAct_r[7:0] && outFirst_r);
					if (cycleEnd) begin
						outSecond_r <= (cycleAct_r[15:8] == 8'h00);
					end else if ((count_r[7:0] + 8'h01) == cycleAct_r[15:8]) begin
						outSecond_r <= 1'b1;
					end else if ((count_r[7:0] + 8'h01) == pulseAct_r[15:8]) begin
						outSecond_r <= 1'b0;
					end
				end
				dcpwm_pkg::MODE_TWIN16: begin
					outFirst_r <= cycleEnd || ((count_r + 16'h0001) < pulseAct_r);
					outSecond_r <= cycleEnd || ((count_r + 16'h0001) < cycleAct_r);
				end
				dcpwm_pkg::MODE_DUAL8: begin
					outFirst_r <= cycleEnd || ((count_r[7:0] + 8'h01) < pulseAct_r[7:0]);
					outSecond_r <= cycleEnd || ((count_r[7:0] + 8'h01) < pulseAct_r[15:8]);
				end
				dcpwm_pkg::MODE_NRZ, dcpwm_pkg::MODE_RZ: begin
					outFirst_r <= ({1'b0, accFirst_r[15:0]} + {1'b0, pulseAct_r}) > 17'h0_FFFF;
					outSecond_r <= ({1'b0, accSecond_r[15:0]} + {1'b0, cycleAct_r}) > 17'h0_FFFF;
				end
				default: begin
					outFirst_r <= 1'b0;
					outSecond_r <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Return to zero: half phase counts source rising edges within one PWM clock.
	// Exact halving needs an even divider, hence divide by four works best.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rzPhase_r <= 1'b0;
		end else if (pwmTick) begin
			rzPhase_r <= 1'b1;
		end else if (divCnt_r >= {1'b0, divTc[5:1]}) begin
			rzPhase_r <= 1'b0;
		end
	end

	// Registered pin drive, gated low in the second half for mode 6
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rzFirst_r <= 1'b0;
			rzSecond_r <= 1'b0;
		end else if (mode == dcpwm_pkg::MODE_RZ) begin
			rzFirst_r <= outFirst_r && (rzPhase_r || pwmTick);
			rzSecond_r <= outSecond_r && (rzPhase_r || pwmTick);
		end else begin
			rzFirst_r <= outFirst_r;
			rzSecond_r <= outSecond_r;
		end
	end

	// Pin ownership: off and hold modes hand the pins back to the port
	assign pinOe = !(mode == dcpwm_pkg::MODE_OFF || mode == dcpwm_pkg::MODE_HOLD);
	assign pinOut.first = pinOe && rzFirst_r;
	assign pinOut.second = pinOe && rzSecond_r && (mode != dcpwm_pkg::MODE_SINGLE);

endmodule

// ### dv/dcpwm_props.sv
// Checker of register bus and pin behaviour of the modulator
`timescale 1ns/1ps
module dcpwm_props (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Watched ports
	input wire logic [3:0] sourceTick,
	input wire dcpwm_pkg::dcpwm_sfr_req_type sfrReq,
	input wire logic [7:0] sfrRdata,
	input wire logic sfrHit,
	input wire dcpwm_pkg::dcpwm_pins_type pinOut,
	input wire logic pinOe
);
	logic [6:0] ctlR;
	logic srcR;
	logic [2:0] riseAge;
	logic [2:0] ctlAge;
	wire logic [2:0] mode = ctlR[6:4];
	wire logic dataA = sfrReq.addr inside {[8'h00_B1:8'h00_B4]};
	wire logic ctlA = sfrReq.addr == dcpwm_pkg::ADDR_CONTROL;
	// Control copy and ages; ages saturate so a stale edge never wraps back
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctlR <= '0;
			srcR <= 1'b0;
			riseAge <= 3'h7;
			ctlAge <= 3'h0;
		end else begin
			srcR <= sourceTick[ctlR[1:0]];
			riseAge <= (sourceTick[ctlR[1:0]] && !srcR) ? 3'h0 : riseAge + 3'(riseAge != 3'h7);
			ctlAge <= (sfrReq.write && ctlA) ? 3'h0 : ctlAge + 3'(ctlAge != 3'h7);
			if (sfrReq.write && ctlA) begin
				ctlR <= sfrReq.wdata[6:0];
			end
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence dataWr;
		sfrReq.write && dataA ##1 sfrReq.addr == $past(sfrReq.addr);
	endsequence
	sequence ctlWr;
		sfrReq.write && ctlA ##1 ctlA;
	endsequence
	a_unmapped_reads_zero: assert property (!sfrHit |-> sfrRdata == 8'h00_00) else $error("unmapped read");
	a_hit_decode: assert property (sfrHit == (dataA || ctlA)) else $error("decode wrong");
	a_data_readback: assert property (dataWr |-> sfrRdata == $past(sfrReq.wdata)) else $error("readback");
	a_control_masked: assert property (ctlWr |-> sfrRdata == ($past(sfrReq.wdata) & 8'h00_7F))
		else $error("control readback");
	a_oe_after_write: assert property (ctlWr |-> pinOe == !($past(sfrReq.wdata[6:4]) inside {3'h0, 3'h7}))
		else $error("enable after write");
	a_oe_by_mode: assert property (pinOe == (mode != 3'h0 && mode != 3'h7)) else $error("enable");
	a_released_low: assert property (!pinOe |-> !pinOut.first && !pinOut.second) else $error("pins");
	a_single_second_low: assert property (mode == 3'h1 && ctlAge > 3'h2 |-> !pinOut.second)
		else $error("second output in single mode");
	a_change_needs_tick: assert property (ctlAge > 3'h3 && mode != 3'h6 && $changed(pinOut) |-> riseAge < 3'h5)
		else $error("pin moved without tick");
endmodule
bind dcpwm_core dcpwm_props u_dcpwm_props (.clock(clock), .reset_n(reset_n), .sourceTick(sourceTick),
	.sfrReq(sfrReq), .sfrRdata(sfrRdata), .sfrHit(sfrHit), .pinOut(pinOut), .pinOe(pinOe));

// ### dv/dcpwm_load.sv
// Load model on the two pins: pull-ups and a high-time integrator
`timescale 1ns/1ps
module dcpwm_load (
	// Clock and counter clear
	input wire logic clock,
	input wire logic clear,
	// Pins
	input wire dcpwm_pkg::dcpwm_pins_type pinOut,
	input wire logic pinOe,
	// Line levels and high counts
	output logic [1:0] line,
	output int firstHigh,
	output int secondHigh
);
	// Released lines float to the pull-up level
	assign line = pinOe ? {pinOut.first, pinOut.second} : 2'b11;
	// Integrate clocks spent high, as a filter would
	always_ff @(posedge clock) begin
		if (clear) begin
			firstHigh <= 0;
			secondHigh <= 0;
		end else begin
			firstHigh <= firstHigh + int'(line[1]);
			secondHigh <= secondHigh + int'(line[0]);
		end
	end
endmodule

// ### dv/dual_channel_pwm_sigma_delta_tb.sv
// Self-checking bench of the dual channel modulator
`timescale 1ns/1ps
module dual_channel_pwm_sigma_delta_tb;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic clear = 1'b0;
	logic [3:0] sourceTick = 4'h0;
	dcpwm_pkg::dcpwm_sfr_req_type sfrReq = '0;
	logic [7:0] sfrRdata;
	logic sfrHit;
	dcpwm_pkg::dcpwm_pins_type pinOut;
	logic pinOe;
	logic [1:0] line;
	int firstHigh;
	int secondHigh;
	int failures = 0;
	int checks = 0;
	logic [7:0] v;
	logic [7:0] c;
	logic [2:0] m;
	// Clock; sources rise every 2, 4, 8 and 16 clocks
	always #2.5 clock = ~clock;
	always @(posedge clock) sourceTick <= sourceTick + 4'h1;
	dcpwm_core u_dcpwm_core (.clock(clock), .reset_n(reset_n), .sourceTick(sourceTick), .sfrReq(sfrReq),
		.sfrRdata(sfrRdata), .sfrHit(sfrHit), .pinOut(pinOut), .pinOe(pinOe));
	dcpwm_load u_dcpwm_load (.clock(clock), .clear(clear), .pinOut(pinOut), .pinOe(pinOe), .line(line),
		.firstHigh(firstHigh), .secondHigh(secondHigh));
	// Compare and count
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe, low for a cycle after
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfrReq <= {1'b1, 1'b0, a, d};
		@(posedge clock);
		sfrReq.write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		sfrReq.addr <= a;
		@(negedge clock);
		cmp(sfrRdata, e);
	endtask
	// High ticks per period of one output; released lines read high
	function automatic int hiTicks(input logic [2:0] md, input bit sec, input int pl, ph, ch, per);
		if (md == 3'h0 || md == 3'h7) return per;
		if (md == 3'h4 || md == 3'h6) return sec ? 1 : 2;
		if (!sec) return pl;
		return (md == 3'h5) ? ph : (md == 3'h2) ? ph - ch : 0;
	endfunction
	// Program, let it settle, then integrate over whole periods
	task automatic run(input logic [2:0] md, input logic [7:0] pl, ph, cl, ch, input logic [1:0] s, dv);
		int sp;
		int per;
		int n;
		sp = (2 << s) * (1 << (2 * dv));
		per = (md == 3'h5) ? 256 : (md == 3'h4 || md == 3'h6) ? 8 : (md == 3'h0 || md == 3'h7) ? 4 : cl + 1;
		n = 2 * per * sp;
		wr(dcpwm_pkg::ADDR_PULSE_LOW, pl);
		wr(dcpwm_pkg::ADDR_PULSE_HIGH, ph);
		wr(dcpwm_pkg::ADDR_CYCLE_LOW, cl);
		wr(dcpwm_pkg::ADDR_CYCLE_HIGH, ch);
		wr(dcpwm_pkg::ADDR_CONTROL, {1'b0, md, dv, s});
		repeat (n + 8) @(posedge clock);
		clear <= 1'b1;
		@(posedge clock);
		clear <= 1'b0;
		repeat (n) @(posedge clock);
		#1;
		// Return to zero keeps each high clock up for half of it only
		cmp(firstHigh, 2 * sp * hiTicks(md, 0, pl, ph, ch, per) / ((md == 3'h6) ? 2 : 1));
		cmp(secondHigh, 2 * sp * hiTicks(md, 1, pl, ph, ch, per) / ((md == 3'h6) ? 2 : 1));
	endtask
	// Budget under 47k clocks of tests; cut off well beyond, at 80k
	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(52791));
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		for (int a = 8'h00_B1; a <= 8'h00_B4; a++) begin
			rd(8'(a), 8'h00_00);
			v = 8'($urandom);
			wr(8'(a), v);
			rd(8'(a), v);
		end
		rd(dcpwm_pkg::ADDR_CONTROL, 8'h00_00);
		wr(dcpwm_pkg::ADDR_CONTROL, 8'h00_FF);
		rd(dcpwm_pkg::ADDR_CONTROL, 8'h00_7F);
		wr(8'h00_B5, 8'h00_A5);
		rd(8'h00_B5, 8'h00_00);
		cmp(sfrHit, 1'b0);
		for (int i = 0; i < 8; i++) begin
			wr(dcpwm_pkg::ADDR_CONTROL, 8'(i << 4));
			@(negedge clock);
			cmp(pinOe, i != 0 && i != 7);
		end
		run(3'h2, 8'h00_05, 8'h00_06, 8'h00_09, 8'h00_00, 2'h0, 2'h0);
		run(3'h4, 8'h00_00, 8'h00_40, 8'h00_00, 8'h00_20, 2'h0, 2'h0);
		// Divide by four, low bits padded with a final one
		run(3'h6, 8'h00_01, 8'h00_40, 8'h00_00, 8'h00_20, 2'h0, 2'h1);
		run(3'h5, 8'h00_01, 8'h00_FF, 8'h00_00, 8'h00_00, 2'h0, 2'h0);
		// Mode 3: both rise at restart; second stays up two ticks longer, then both low
		wr(dcpwm_pkg::ADDR_PULSE_LOW, 8'h00_02);
		wr(dcpwm_pkg::ADDR_PULSE_HIGH, 8'h00_00);
		wr(dcpwm_pkg::ADDR_CYCLE_LOW, 8'h00_04);
		wr(dcpwm_pkg::ADDR_CYCLE_HIGH, 8'h00_00);
		wr(dcpwm_pkg::ADDR_CONTROL, 8'h00_30);
		clear <= 1'b1;
		@(posedge clock);
		clear <= 1'b0;
		repeat (40) @(posedge clock);
		#1;
		cmp(secondHigh - firstHigh, 32'd4);
		cmp(pinOut, 2'b00);
		run(3'h1, 8'h00_03, 8'h00_00, 8'h00_04, 8'h00_00, 2'h0, 2'h3);
		run(3'h0, 8'h00_03, 8'h00_00, 8'h00_04, 8'h00_00, 2'h1, 2'h0);
		run(3'h7, 8'h00_03, 8'h00_00, 8'h00_04, 8'h00_00, 2'h2, 2'h0);
		for (int i = 0; i < 10; i++) begin
			m = ($urandom % 3 == 0) ? 3'h1 : ($urandom % 2 == 0) ? 3'h2 : 3'h5;
			c = 8'(3 + $urandom % 13);
			v = 8'(1 + $urandom % c);
			if (m == 3'h1) run(m, v, 8'h00_00, c, 8'h00_00, 2'($urandom), 2'($urandom % 2));
			else if (m == 3'h2) run(m, v, c, c, 8'($urandom % c), 2'($urandom), 2'($urandom % 2));
			else run(m, v, c, c, 8'h00_00, 2'h0, 2'h0);
		end
		tally_and_finish();
	end
endmodule
